// >>> esr_detect.sv
// one signal's polarity and sensitivity stage
`default_nettype none
module esr_detect
  import esr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sig,
  input wire logic [1:0] sens,
  input wire logic clr,
  output logic raw
);
  logic prev_q, prev_d;
  logic lat_q, lat_d;
  logic hit;

  always_comb
  begin
    prev_d = sig;
    case (sens)
      ESR_SENS_RISE: hit = sig & ~prev_q;
      ESR_SENS_FALL: hit = ~sig & prev_q;
      default: hit = 1'b0;
    endcase
    // edge capture is sticky; a new edge beats a same-cycle clear
    lat_d = hit | (lat_q & ~clr);
    if (!sens[1])
    begin
      lat_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prev_q <= 1'b0;
      lat_q <= 1'b0;
    end
    else if (ce)
    begin
      prev_q <= prev_d;
      lat_q <= lat_d;
    end
  end

  // level modes follow the pin, edge modes show the capture
  assign raw = sens[1] ? lat_q : (sig ^ sens[0]);
endmodule : esr_detect
`default_nettype wire

// >>> esr_far_end.sv
// model of the interrupt controller and wake-up logic beside the router
`default_nettype none
module esr_far_end
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] int_ctrl_out,
  input wire logic [3:0] int_en,
  input wire logic clock_gen_unit_wake,
  output logic cpu_int,
  output var logic wake_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wake_d;
  // each of router outputs 0 to 3 enabled on its own
  assign cpu_int = |(int_ctrl_out & int_en);
  // wake kept until reset, a short pulse must not be lost
  assign wake_d = wake_q | clock_gen_unit_wake;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_q <= 1'h0;
    end
    else
    begin
      wake_q <= wake_d;
    end
  end
endmodule : esr_far_end
`default_nettype wire

// >>> esr_pkg.sv
// shared constants of the event signal router
`default_nettype none
package esr_pkg;
  localparam int ESR_NUM_SIG = 105;
  localparam int ESR_NUM_OUT = 5;
  localparam int ESR_GRP = 4;
  localparam int ESR_SENS_REGS = 7;
  localparam int ESR_AW = 10;
  // sensitivity codes, two bits per signal
  localparam logic [1:0] ESR_SENS_HIGH = 2'h0;
  localparam logic [1:0] ESR_SENS_LOW = 2'h1;
  localparam logic [1:0] ESR_SENS_RISE = 2'h2;
  localparam logic [1:0] ESR_SENS_FALL = 2'h3;
  // byte offsets and address pages
  localparam logic [9:0] ESR_RAW0 = 10'h000;
  localparam logic [9:0] ESR_PEND0 = 10'h010;
  localparam logic [9:0] ESR_GMASK0 = 10'h020;
  localparam logic [9:0] ESR_SENS0 = 10'h030;
  localparam logic [9:0] ESR_OUTST = 10'h050;
  localparam logic [9:0] ESR_IRQST = 10'h054;
  localparam logic [9:0] ESR_IRQMSK = 10'h058;
  localparam logic [1:0] ESR_OMASK_PAGE = 2'h1;
  localparam logic [1:0] ESR_OPEND_PAGE = 2'h2;
  // reset values
  localparam logic [31:0] ESR_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] ESR_RST_SENS = ESR_SENS_HIGH;
endpackage : esr_pkg
`default_nettype wire

// >>> esr_router.sv
// event signal router: detection, global mask, five masked outputs
// Notes on behaviour
// - takes 105 pin or internal signals
// - per-signal high, low, rising or falling sensitivity
// - detection results readable in four raw registers
// - global mask per signal makes pending
// - pending readable in four pending registers
// - all pending feed five output blocks
// - each output has four mask registers, 105 bits
// - mask AND pending, ORed into each output
// - all 105 products readable per output
// - outputs 0 to 3 go to interrupt controller
// - output 4 goes to clock_gen_unit wake-up
// - all five outputs read in one register
// - any signal usable as interrupt or enable source
`default_nettype none
module esr_router
  import esr_pkg::*;
#(
  parameter int NUM_SIG = ESR_NUM_SIG,
  parameter int NUM_OUT = ESR_NUM_OUT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [NUM_SIG-1:0] sig_in,
  input wire logic [ESR_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [3:0] int_ctrl_out,
  output logic clock_gen_unit_wake,
  output logic irq
);
  localparam int W = 32 * ESR_GRP;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NUM_SIG-1:0] s1_q, s2_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= sig_in;
      s2_q <= s1_q;
    end
  end

  // ****************************************
  // register state
  // ****************************************
  logic [W-1:0] gmask_q, gmask_d;
  logic [NUM_OUT-1:0][W-1:0] omask_q, omask_d;
  logic [ESR_SENS_REGS*32-1:0] sens_q, sens_d;
  logic [NUM_OUT-1:0] out_q, out_d;
  logic [NUM_OUT-1:0] ist_q, ist_d;
  logic [NUM_OUT-1:0] imsk_q, imsk_d;
  logic [31:0] rdata_q, rdata_d;
  logic [W-1:0] raw, pend, clr;
  logic [NUM_OUT-1:0][W-1:0] opend;
  logic [1:0] page;
  logic [2:0] osel;
  logic [1:0] wsel;
  logic [5:0] widx;

  assign page = addr[9:8];
  assign osel = addr[6:4];
  assign wsel = addr[3:2];
  assign widx = addr[7:2];

  // ****************************************
  // detection stage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SIG; g++)
    begin : g_det
      esr_detect u_det (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .sig(s2_q[g]),
        .sens(sens_q[2*g +: 2]),
        .clr(clr[g]),
        .raw(raw[g])
      );
    end
    // unused top bits of the last word read zero
    for (g = NUM_SIG; g < W; g++)
    begin : g_pad
      assign raw[g] = 1'b0;
    end
  endgenerate

  // ****************************************
  // masking and output logic
  // ****************************************
  always_comb
  begin
    pend = raw & gmask_q;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      opend[o] = pend & omask_q[o];
      out_d[o] = |opend[o];
    end
  end

  assign int_ctrl_out = out_q[3:0];
  assign clock_gen_unit_wake = out_q[4];
  assign irq = |(ist_q & imsk_q);
  assign rdata = rdata_q;

  // ****************************************
  // register writes
  // ****************************************
  always_comb
  begin
    gmask_d = gmask_q;
    omask_d = omask_q;
    sens_d = sens_q;
    imsk_d = imsk_q;
    clr = '0;
    // output rises are sticky; a rise beats a same-cycle clear
    ist_d = ist_q | (out_d & ~out_q);
    if (wr)
    begin
      if (page == 2'h0)
      begin
        // only edge captures clear; level bits keep following the pin
        if (widx < 6'(ESR_GRP))
        begin
          clr[32*wsel +: 32] = wdata;
        end
        else if (addr[7:4] == ESR_GMASK0[7:4])
        begin
          gmask_d[32*wsel +: 32] = wdata;
        end
        else if (widx >= ESR_SENS0[7:2]
                 && widx < 6'(ESR_SENS0[7:2] + ESR_SENS_REGS))
        begin
          sens_d[32*(widx - ESR_SENS0[7:2]) +: 32] = wdata;
        end
        else if (addr[7:0] == ESR_IRQST[7:0])
        begin
          ist_d = ist_q & ~wdata[NUM_OUT-1:0];
          ist_d = ist_d | (out_d & ~out_q);
        end
        else if (addr[7:0] == ESR_IRQMSK[7:0])
        begin
          imsk_d = wdata[NUM_OUT-1:0];
        end
      end
      else if (page == ESR_OMASK_PAGE && osel < 3'(NUM_OUT))
      begin
        omask_d[osel][32*wsel +: 32] = wdata;
      end
    end
    // bits above the last signal never hold a one
    gmask_d[W-1:NUM_SIG] = '0;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      omask_d[o][W-1:NUM_SIG] = '0;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb
  begin
    rdata_d = ESR_RST_WORD;
    if (rd)
    begin
      if (page == 2'h0)
      begin
        if (widx < 6'(ESR_GRP))
        begin
          rdata_d = raw[32*wsel +: 32];
        end
        else if (addr[7:4] == ESR_PEND0[7:4])
        begin
          rdata_d = pend[32*wsel +: 32];
        end
        else if (addr[7:4] == ESR_GMASK0[7:4])
        begin
          rdata_d = gmask_q[32*wsel +: 32];
        end
        else if (widx >= ESR_SENS0[7:2]
                 && widx < 6'(ESR_SENS0[7:2] + ESR_SENS_REGS))
        begin
          rdata_d = sens_q[32*(widx - ESR_SENS0[7:2]) +: 32];
        end
        else if (addr[7:0] == ESR_OUTST[7:0])
        begin
          rdata_d[NUM_OUT-1:0] = out_q;
        end
        else if (addr[7:0] == ESR_IRQST[7:0])
        begin
          rdata_d[NUM_OUT-1:0] = ist_q;
        end
        else if (addr[7:0] == ESR_IRQMSK[7:0])
        begin
          rdata_d[NUM_OUT-1:0] = imsk_q;
        end
      end
      else if (page == ESR_OMASK_PAGE && osel < 3'(NUM_OUT))
      begin
        rdata_d = omask_q[osel][32*wsel +: 32];
      end
      else if (page == ESR_OPEND_PAGE && osel < 3'(NUM_OUT))
      begin
        rdata_d = opend[osel][32*wsel +: 32];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gmask_q <= '0;
      omask_q <= '0;
      sens_q <= '0;
      out_q <= '0;
      ist_q <= '0;
      imsk_q <= '0;
      rdata_q <= ESR_RST_WORD;
    end
    else if (ce)
    begin
      gmask_q <= gmask_d;
      omask_q <= omask_d;
      sens_q <= sens_d;
      out_q <= out_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // each one-cycle-ahead check asks for ce, as a frozen cycle holds state
  sequence s_rise0;
    ce && sens_q[1:0] == ESR_SENS_RISE && s2_q[0] && !$past(s2_q[0]);
  endsequence

  sequence s_irq_rise;
    ce && !wr && |(imsk_q & out_d & ~out_q);
  endsequence

  a_level_follow: assert property (@(posedge clk) disable iff (reset)
    sens_q[1:0] == ESR_SENS_LOW |-> raw[0] == !s2_q[0])
    else $error("low-level raw bit does not follow inverted input");

  a_edge_hold: assert property (@(posedge clk) disable iff (reset)
    s_rise0 ##1 (ce && !clr[0] && sens_q[1:0] == ESR_SENS_RISE)
    |=> raw[0])
    else $error("rising edge not held in raw bit");

  a_pend_gate: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr == ESR_PEND0 + 10'h00C && !gmask_q[104]
    |=> !rdata[8])
    else $error("masked signal shows in pending read");

  a_out_follow: assert property (@(posedge clk) disable iff (reset)
    ce && (opend[0] != '0) |=> out_q[0])
    else $error("output 0 missed an enabled pending signal");

  a_out_quiet: assert property (@(posedge clk) disable iff (reset)
    ce && (omask_q[4] == '0) |=> !clock_gen_unit_wake)
    else $error("wake output high with empty mask");

  a_outst_read: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr == ESR_OUTST |=> rdata == {27'h0, $past(out_q)})
    else $error("output status read wrong");

  a_pend_read: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr == ESR_PEND0 |=> rdata == $past(pend[31:0]))
    else $error("pending word 0 read wrong");

  a_raw_top: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr == ESR_RAW0 + 10'h00C |=> rdata[31:9] == '0)
    else $error("unused raw bits read nonzero");

  a_opend_read: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr == 10'h240 |=> rdata == $past(opend[4][31:0]))
    else $error("output 4 pending word read wrong");

  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    s_irq_rise |=> irq)
    else $error("unmasked output rise did not raise the interrupt");
endmodule : esr_router
`default_nettype wire

// >>> esr_router_tb.sv
// self-checking testbench of the event signal router
`default_nettype none
module esr_router_tb
  import esr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] sens;
    logic lvl0;
    logic lvl1;
    logic hit;
  } esr_row_s;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic ce = 1'h1;
  logic [ESR_NUM_SIG-1:0] sig_in = '0;
  logic [ESR_AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [3:0] int_en = 4'h0;
  logic [31:0] rdata;
  logic [3:0] int_ctrl_out;
  logic clock_gen_unit_wake;
  logic irq;
  logic cpu_int;
  logic wake_q;
  int errors = 0;
  int comparisons = 0;
  // rows 0, 2 and 5 end high; each row drives its own start level before its clear
  esr_row_s rows [6] = '{
    '{ESR_SENS_HIGH, 1'h0, 1'h1, 1'h1},
    '{ESR_SENS_LOW, 1'h1, 1'h0, 1'h1},
    '{ESR_SENS_RISE, 1'h0, 1'h1, 1'h1},
    '{ESR_SENS_FALL, 1'h1, 1'h0, 1'h1},
    '{ESR_SENS_RISE, 1'h1, 1'h0, 1'h0},
    '{ESR_SENS_FALL, 1'h0, 1'h1, 1'h0}};

  always #10 clk = ~clk;

  esr_router esr_router_i (.clk(clk), .reset(reset), .ce(ce),
    .sig_in(sig_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .int_ctrl_out(int_ctrl_out),
    .clock_gen_unit_wake(clock_gen_unit_wake), .irq(irq));
  esr_far_end esr_far_end_i (.clk(clk), .reset(reset),
    .int_ctrl_out(int_ctrl_out), .int_en(int_en),
    .clock_gen_unit_wake(clock_gen_unit_wake), .cpu_int(cpu_int),
    .wake_q(wake_q));

  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic reg_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk_word(rdata, exp);
  endtask : reg_rd

  initial
  begin
    #100000;
    errors++;
    end_sim;
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    reg_rd(ESR_GMASK0, ESR_RST_WORD);
    reg_rd(ESR_SENS0, ESR_RST_WORD);
    reg_rd(ESR_OUTST, 32'h0);
    reg_wr(10'h3FC, 32'hFFFF_FFFF);
    reg_rd(10'h3FC, 32'h0);
    reg_wr(ESR_GMASK0, 32'h1);
    reg_wr(10'h100, 32'h1);
    foreach (rows[i])
    begin
      reg_wr(ESR_SENS0, {30'h0, rows[i].sens});
      sig_in[0] <= rows[i].lvl0;
      repeat (4) @(posedge clk);
      // clear latches left by the previous row or the start-level step
      reg_wr(ESR_RAW0, 32'h1);
      sig_in[0] <= rows[i].lvl1;
      repeat (5) @(posedge clk);
      reg_rd(ESR_RAW0, {31'h0, rows[i].hit});
      reg_rd(ESR_PEND0, {31'h0, rows[i].hit});
      chk_bit(int_ctrl_out[0], rows[i].hit);
    end
    // last signal, upper word, two outputs at once
    reg_wr(ESR_IRQST, 32'h1F);
    reg_wr(10'h14C, 32'h100);
    reg_wr(10'h12C, 32'h100);
    sig_in[104] <= 1'h1;
    repeat (5) @(posedge clk);
    reg_rd(ESR_RAW0 + 10'hC, 32'h100);
    reg_rd(ESR_PEND0 + 10'hC, 32'h0);
    reg_wr(ESR_GMASK0 + 10'hC, 32'h100);
    repeat (3) @(posedge clk);
    reg_rd(ESR_PEND0 + 10'hC, 32'h100);
    reg_rd(10'h24C, 32'h100);
    reg_rd(10'h20C, 32'h0);
    reg_rd(ESR_OUTST, 32'h14);
    chk_bit(clock_gen_unit_wake, 1'h1);
    chk_word({28'h0, int_ctrl_out}, 32'h4);
    int_en <= 4'h4;
    @(posedge clk);
    #1 chk_bit(cpu_int, 1'h1);
    chk_bit(wake_q, 1'h1);
    reg_rd(ESR_IRQST, 32'h14);
    chk_bit(irq, 1'h0);
    reg_wr(ESR_IRQMSK, 32'h4);
    #1 chk_bit(irq, 1'h1);
    reg_wr(ESR_IRQST, 32'h4);
    #1 chk_bit(irq, 1'h0);
    reg_rd(ESR_IRQST, 32'h10);
    // a second rise of output 2 raises the line again
    @(posedge clk);
    sig_in[104] <= 1'h0;
    repeat (5) @(posedge clk);
    sig_in[104] <= 1'h1;
    repeat (5) @(posedge clk);
    #1 chk_bit(irq, 1'h1);
    reg_wr(ESR_IRQST, 32'h14);
    #1 chk_bit(irq, 1'h0);
    // strobes while frozen must be dropped
    @(posedge clk);
    ce <= 1'h0;
    reg_wr(ESR_GMASK0 + 10'hC, 32'h0);
    ce <= 1'h1;
    reg_rd(ESR_GMASK0 + 10'hC, 32'h100);
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk_bit(clock_gen_unit_wake, 1'h0);
    @(posedge clk);
    reset <= 1'h0;
    reg_rd(ESR_GMASK0 + 10'hC, 32'h0);
    reg_rd(10'h14C, 32'h0);
    end_sim;
  end
endmodule : esr_router_tb
`default_nettype wire
